/* File: lpdram_cfg.svh */
// constants for the lpdram command execution block
`ifndef LPDRAM_CFG_SVH
`define LPDRAM_CFG_SVH
`define COL_W 11
`define BANK_W 3
`define ROW_W 14
`define ADDR_W 28
`define DATA_W 32
`define MASK_W 4
`define CMD_READ 4'h1
`define CMD_WRITE 4'h2
`define CMD_READ_AC 4'h3
`define CMD_WRITE_AC 4'h4
`define CMD_MRW 4'h6
`define CMD_MRR 4'h7
`define MR_NUM_LSB 0
`define MR_OP_LSB 8
`define MR_BL 8'h01
`define MR_RL 8'h02
`define MR_DS 8'h03
`define INIT_BL 3'h3
`define INIT_RL 4'h4
`define INIT_DS 4'h2
`define BEATS_PER_CMD 2
`define REFRESH_INTERVAL_NS 3900
`define REFRESH_INTERVAL_CYC ((`REFRESH_INTERVAL_NS * 250) / 1000)
`define ALLBANK_REFRESH_NS 210
`define ALLBANK_REFRESH_CYC (((`ALLBANK_REFRESH_NS * 250) + 999) / 1000)
`define REFRESH_SLOT_CYC (4 * `ALLBANK_REFRESH_CYC)
`define MAX_BURST 14'h2000
`define WR_WAIT_CYC 4
`define RD_WAIT_CYC 6
`endif

/* File: lpdram_cmd_exec.sv */
// user command execution: row management, write and read data, mode registers
//
// Contract
// R1: raise write request once data can be taken
// R2: user waits on write request, not latency
// R3: data sampled one or two cycles after request
// R4: closed bank gets activate then write
// R5: other row open: precharge, activate, write
// R6: row hit sends only the write
// R7: write autoclose issues write with auto precharge
// R8: read valid marks returned read data
// R9: reads use same open-row checking
// R10: read autoclose issues read with auto precharge
// R11: internal refresh burst each interval times count
// R12: no other memory command during refresh burst
// R13: precharge only before first burst refresh
// R14: external port disables timer, acks each burst
// R15: user may hold refresh request low
// R16: bank field three bits, chip select none
// R17: column low, bank next, row above
// R18: mode registers reached via address bus only
// R19: register number low byte, opcode next byte
// R20: mode register write updates own configuration
// R21: init values hold until later register write
// R22: register read gives two-cycle valid, data first
// R23: only defined four-bit codes, others discarded
// R24: command taken when ready and valid both high
// R25: mode commands ignore address above bit fifteen
`timescale 1ns/1ps
`include "lpdram_cfg.svh"
module lpdram_cmd_exec (
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic i_cmd_valid,
  input wire lpdram_pkg::user_cmd_t i_cmd,
  input wire logic [`ADDR_W-1:0] i_addr,
  output logic o_cmd_ready,
  input wire logic i_payload_lag2,
  output logic o_write_request,
  input wire logic [`DATA_W-1:0] i_write_data,
  input wire logic [`MASK_W-1:0] i_write_mask,
  output logic [`DATA_W-1:0] o_read_data,
  output logic o_read_valid,
  input wire logic i_ext_refresh_enable,
  input wire logic i_ext_refresh_request,
  input wire logic [13:0] i_refresh_burst_count,
  output logic o_ext_refresh_ack,
  output lpdram_pkg::mem_cmd_t o_mem_cmd,
  output logic o_mem_auto_precharge,
  output logic [`BANK_W-1:0] o_mem_bank,
  output logic [`ROW_W-1:0] o_mem_row,
  output logic [`COL_W-1:0] o_mem_col,
  output logic [7:0] o_mem_mr_num,
  output logic [7:0] o_mem_mr_op,
  output logic [`DATA_W-1:0] o_mem_write_data,
  output logic [`MASK_W-1:0] o_mem_write_mask,
  output logic o_mem_write_strobe,
  input wire logic [`DATA_W-1:0] i_mem_read_data,
  input wire logic i_mem_read_strobe,
  output logic [2:0] o_burst_length_code,
  output logic [3:0] o_latency_code,
  output logic [3:0] o_drive_code
);
  import lpdram_pkg::*;

  typedef enum logic [3:0] {
    ST_IDLE, ST_PRE, ST_ACT, ST_ISSUE, ST_WDATA, ST_RWAIT, ST_MRR1, ST_MRR2, ST_REFRESH
  } state_t;

  function automatic logic is_defined(input user_cmd_t c);
    return c == `CMD_READ || c == `CMD_WRITE || c == `CMD_READ_AC ||
           c == `CMD_WRITE_AC || c == `CMD_MRW || c == `CMD_MRR;
  endfunction
  function automatic logic is_write(input user_cmd_t c);
    return c == `CMD_WRITE || c == `CMD_WRITE_AC;
  endfunction

  state_t state_r;
  state_t state_nxt;
  user_cmd_t cmd_r;
  logic [`ADDR_W-1:0] addr_r;
  logic [7:0] open_r;
  logic [`ROW_W-1:0] open_row_r [8];
  logic [3:0] wait_r;
  logic [2:0] req_pipe_r;
  logic [1:0] beat_r;
  logic [2:0] bl_r;
  logic [3:0] rl_r;
  logic [3:0] ds_r;
  logic [7:0] mr_data_r;
  logic [`DATA_W-1:0] rdata_r;
  logic rvalid_r;
  logic [`DATA_W-1:0] wdata_r;
  logic [`MASK_W-1:0] wmask_r;
  logic wstrobe_r;
  logic ref_busy;
  logic ref_pre;
  logic ref_refresh;

  ////////////////////////////////////////////////////////////////////////
  // address split and row status
  wire [`COL_W-1:0] col = addr_r[`COL_W-1:0]; // see R17
  wire [`BANK_W-1:0] bank = addr_r[`COL_W+`BANK_W-1:`COL_W]; // see R16
  wire [`ROW_W-1:0] row = addr_r[`ADDR_W-1:`COL_W+`BANK_W];
  wire bank_open = open_r[bank];
  wire row_hit = bank_open && (open_row_r[bank] == row);
  wire autoclose = (cmd_r == `CMD_WRITE_AC) || (cmd_r == `CMD_READ_AC);
  wire mode_cmd = (cmd_r == `CMD_MRW) || (cmd_r == `CMD_MRR);
  // ignored bits above 15 and opcode on reads
  wire [7:0] mr_num = addr_r[`MR_NUM_LSB+7:`MR_NUM_LSB]; // see R19, R25
  wire [7:0] mr_op = (cmd_r == `CMD_MRW) ? addr_r[`MR_OP_LSB+7:`MR_OP_LSB] : 8'h00; // see R25
  wire accept = o_cmd_ready && i_cmd_valid; // see R24
  wire lag_tap = i_payload_lag2 ? req_pipe_r[1] : req_pipe_r[0]; // see R3

  assign o_cmd_ready = (state_r == ST_IDLE) && !ref_busy;

  ////////////////////////////////////////////////////////////////////////
  // sequencer
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: begin
        if (ref_busy) begin
          state_nxt = ST_REFRESH; // see R12
        end else if (accept && is_defined(i_cmd)) begin // see R23
          state_nxt = ST_PRE;
        end
      end
      ST_PRE: begin
        if (mode_cmd) begin
          state_nxt = ST_ISSUE; // see R18
        end else if (row_hit) begin
          state_nxt = ST_ISSUE; // see R6, R9
        end else if (bank_open) begin
          state_nxt = ST_ACT; // see R5
        end else begin
          state_nxt = ST_ACT; // see R4
        end
      end
      ST_ACT: state_nxt = ST_ISSUE;
      ST_ISSUE: begin
        if (cmd_r == `CMD_MRR) begin
          state_nxt = ST_RWAIT;
        end else if (is_write(cmd_r)) begin
          state_nxt = ST_WDATA;
        end else if (cmd_r == `CMD_MRW) begin
          state_nxt = ST_IDLE;
        end else begin
          state_nxt = ST_RWAIT;
        end
      end
      ST_WDATA: state_nxt = (wait_r == 4'h0) ? ST_IDLE : ST_WDATA;
      ST_RWAIT: begin
        if (cmd_r == `CMD_MRR && wait_r == 4'h0) begin
          state_nxt = ST_MRR1;
        end else if (cmd_r != `CMD_MRR && beat_r == 2'(`BEATS_PER_CMD)) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_MRR1: state_nxt = ST_MRR2;
      ST_MRR2: state_nxt = ST_IDLE;
      ST_REFRESH: state_nxt = ref_busy ? ST_REFRESH : ST_IDLE;
    endcase
  end

  // precharge needed only when a different row sits open
  wire pre_needed = (state_r == ST_PRE) && !mode_cmd && bank_open && !row_hit;

  always_comb begin
    o_mem_cmd = MEM_NOP;
    if (ref_pre) begin
      o_mem_cmd = MEM_PRECHARGE; // see R13
    end else if (ref_refresh) begin
      o_mem_cmd = MEM_REFRESH;
    end else if (pre_needed) begin
      o_mem_cmd = MEM_PRECHARGE; // see R5
    end else if (state_r == ST_ACT) begin
      o_mem_cmd = MEM_ACTIVE; // see R4
    end else if (state_r == ST_ISSUE) begin
      unique case (cmd_r)
        `CMD_MRW: o_mem_cmd = MEM_MRW;
        `CMD_MRR: o_mem_cmd = MEM_MRR;
        `CMD_WRITE, `CMD_WRITE_AC: o_mem_cmd = MEM_WRITE;
        default: o_mem_cmd = MEM_READ;
      endcase
    end
  end
  assign o_mem_auto_precharge = (state_r == ST_ISSUE) && autoclose; // see R7, R10
  assign o_mem_bank = bank;
  assign o_mem_row = row;
  assign o_mem_col = col;
  assign o_mem_mr_num = mr_num;
  assign o_mem_mr_op = mr_op;

  ////////////////////////////////////////////////////////////////////////
  // state, command capture and row table
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      state_r <= ST_IDLE;
      cmd_r <= 4'h0;
      addr_r <= '0;
      open_r <= 8'h00;
    end else begin
      state_r <= state_nxt;
      if (accept && is_defined(i_cmd)) begin
        cmd_r <= i_cmd;
        addr_r <= i_addr;
      end
      if (ref_pre) begin
        open_r <= 8'h00;
      end else if (state_r == ST_ACT) begin
        open_r[bank] <= 1'b1;
      end else if (state_r == ST_ISSUE && autoclose) begin
        open_r[bank] <= 1'b0;
      end
    end
  end
  // row table needs no reset: guarded by open_r
  always_ff @(posedge i_clock) begin
    if (state_r == ST_ACT) begin
      open_row_r[bank] <= row;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // write payload: request pulses, sampled after the configured lag
  wire wreq_fire = (state_r == ST_ISSUE) && is_write(cmd_r);
  assign o_write_request = wreq_fire || (state_r == ST_WDATA && wait_r > 4'h2); // see R1
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      wait_r <= 4'h0;
      req_pipe_r <= 3'h0;
      beat_r <= 2'h0;
      wdata_r <= '0;
      wmask_r <= '0;
      wstrobe_r <= 1'b0;
    end else begin
      req_pipe_r <= {req_pipe_r[1:0], o_write_request};
      if (state_r == ST_ISSUE) begin
        wait_r <= is_write(cmd_r) ? 4'(`WR_WAIT_CYC) : 4'(`RD_WAIT_CYC);
        beat_r <= 2'h0;
      end else if (wait_r != 4'h0) begin
        wait_r <= wait_r - 4'h1;
      end
      if (state_r == ST_RWAIT && i_mem_read_strobe) begin
        beat_r <= beat_r + 2'h1;
      end
      wstrobe_r <= lag_tap;
      if (lag_tap) begin
        wdata_r <= i_write_data; // see R3
        wmask_r <= i_write_mask;
      end
    end
  end
  assign o_mem_write_data = wdata_r;
  assign o_mem_write_mask = wmask_r;
  assign o_mem_write_strobe = wstrobe_r;

  ////////////////////////////////////////////////////////////////////////
  // read return and mode register shadow
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      rdata_r <= '0;
      rvalid_r <= 1'b0;
      mr_data_r <= 8'h00;
      bl_r <= `INIT_BL; // see R21
      rl_r <= `INIT_RL;
      ds_r <= `INIT_DS;
    end else begin
      rvalid_r <= 1'b0;
      if (state_r == ST_RWAIT && cmd_r == `CMD_MRR && i_mem_read_strobe && beat_r == 2'h0) begin
        mr_data_r <= i_mem_read_data[7:0];
      end
      if (state_r == ST_RWAIT && cmd_r != `CMD_MRR && i_mem_read_strobe) begin
        rdata_r <= i_mem_read_data; // see R8
        rvalid_r <= 1'b1;
      end else if (state_nxt == ST_MRR1) begin
        rdata_r <= {24'h0, mr_data_r}; // see R22
        rvalid_r <= 1'b1;
      end else if (state_r == ST_MRR1) begin
        rvalid_r <= 1'b1;
      end
      if (state_r == ST_ISSUE && cmd_r == `CMD_MRW) begin // see R20
        unique case (mr_num)
          `MR_BL: bl_r <= mr_op[2:0];
          `MR_RL: rl_r <= mr_op[3:0];
          `MR_DS: ds_r <= mr_op[3:0];
          default: ;
        endcase
      end
    end
  end
  assign o_read_data = rdata_r;
  assign o_read_valid = rvalid_r;
  assign o_burst_length_code = bl_r;
  assign o_latency_code = rl_r;
  assign o_drive_code = ds_r;

  ////////////////////////////////////////////////////////////////////////
  // refresh
  lpdram_refresh u_refresh (
    .i_clock(i_clock),
    .i_resetn(i_resetn),
    .i_ext_enable(i_ext_refresh_enable),
    .i_ext_request(i_ext_refresh_request), // see R14
    .i_burst_count(i_refresh_burst_count),
    .i_idle(state_r == ST_IDLE || state_r == ST_REFRESH),
    .o_busy(ref_busy),
    .o_precharge(ref_pre),
    .o_refresh(ref_refresh),
    .o_ack(o_ext_refresh_ack)
  );

  ////////////////////////////////////////////////////////////////////////
  // checks
  miss_precharge_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    pre_needed |=> o_mem_cmd == MEM_ACTIVE ##1 o_mem_cmd inside {MEM_WRITE, MEM_READ})
    else $error("row miss did not activate then access"); // see R5
  hit_direct_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (state_r == ST_PRE && !mode_cmd && row_hit) |=> o_mem_cmd inside {MEM_WRITE, MEM_READ})
    else $error("row hit not direct"); // see R6
  autoclose_flag_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (o_mem_cmd == MEM_WRITE && cmd_r == `CMD_WRITE_AC) |-> o_mem_auto_precharge)
    else $error("autoclose flag missing"); // see R7
  refresh_quiet_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (state_r == ST_REFRESH) |-> o_mem_cmd inside {MEM_NOP, MEM_PRECHARGE, MEM_REFRESH})
    else $error("command during refresh"); // see R12
  accept_gate_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (state_r == ST_IDLE && !(o_cmd_ready && i_cmd_valid) && !ref_busy) |=> state_r == ST_IDLE)
    else $error("command taken without handshake"); // see R24
  mrr_pulse_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (state_r == ST_MRR1) |-> (o_read_valid && o_read_data[31:8] == 24'h0) ##1 o_read_valid)
    else $error("mode read valid wrong"); // see R22
  wlag_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (o_write_request && !i_payload_lag2) |=> ##1 o_mem_write_strobe)
    else $error("write data lag wrong"); // see R3
  mrw_cfg_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (state_r == ST_ISSUE && cmd_r == `CMD_MRW && mr_num == `MR_DS) |=> o_drive_code == $past(mr_op[3:0]))
    else $error("drive code not updated"); // see R20
endmodule

/* File: lpdram_command_execution_tb.sv */
// self-checking bench for the lpdram command execution block
`timescale 1ns/1ps
`include "lpdram_cfg.svh"
module lpdram_command_execution_tb;
  import lpdram_pkg::*;
  typedef struct packed {
    mem_cmd_t c; logic [2:0] b; logic [13:0] r; logic [10:0] k; logic ap; logic [7:0] n;
    logic [7:0] o;
  } exp_cmd_t;
  logic i_clock, i_resetn, i_cmd_valid, o_cmd_ready, i_payload_lag2, o_write_request;
  logic i_ext_refresh_enable, i_ext_refresh_request, o_ext_refresh_ack, slow;
  logic o_read_valid, o_mem_auto_precharge, o_mem_write_strobe, i_mem_read_strobe, req_d;
  user_cmd_t i_cmd;
  mem_cmd_t o_mem_cmd;
  logic [27:0] i_addr;
  logic [31:0] i_write_data, o_read_data, o_mem_write_data, i_mem_read_data;
  logic [3:0] i_write_mask, o_mem_write_mask, o_latency_code, o_drive_code;
  logic [13:0] i_refresh_burst_count, o_mem_row;
  logic [2:0] o_mem_bank, o_burst_length_code;
  logic [10:0] o_mem_col;
  logic [7:0] o_mem_mr_num, o_mem_mr_op, open_bank;
  logic [13:0] open_row [8];
  logic [15:0] seed = 16'h8FFE;
  exp_cmd_t ecq[$];
  logic [63:0] rq[$];
  logic [63:0] wq[$];
  int checks = 0;
  int mismatches = 0;
  int acks = 0;

  lpdram_cmd_exec lpdram_cmd_exec_i (.i_clock(i_clock), .i_resetn(i_resetn),
    .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd), .i_addr(i_addr), .o_cmd_ready(o_cmd_ready),
    .i_payload_lag2(i_payload_lag2), .o_write_request(o_write_request),
    .i_write_data(i_write_data), .i_write_mask(i_write_mask), .o_read_data(o_read_data),
    .o_read_valid(o_read_valid), .i_ext_refresh_enable(i_ext_refresh_enable),
    .i_ext_refresh_request(i_ext_refresh_request), .i_refresh_burst_count(i_refresh_burst_count),
    .o_ext_refresh_ack(o_ext_refresh_ack), .o_mem_cmd(o_mem_cmd),
    .o_mem_auto_precharge(o_mem_auto_precharge), .o_mem_bank(o_mem_bank), .o_mem_row(o_mem_row),
    .o_mem_col(o_mem_col), .o_mem_mr_num(o_mem_mr_num), .o_mem_mr_op(o_mem_mr_op),
    .o_mem_write_data(o_mem_write_data), .o_mem_write_mask(o_mem_write_mask),
    .o_mem_write_strobe(o_mem_write_strobe), .i_mem_read_data(i_mem_read_data),
    .i_mem_read_strobe(i_mem_read_strobe), .o_burst_length_code(o_burst_length_code),
    .o_latency_code(o_latency_code), .o_drive_code(o_drive_code));
  lpdram_mem_model lpdram_mem_model_i (.i_clock(i_clock), .i_resetn(i_resetn), .i_slow(slow),
    .i_mem_cmd(o_mem_cmd), .i_bank(o_mem_bank), .i_row(o_mem_row), .i_col(o_mem_col),
    .i_mr_num(o_mem_mr_num), .i_mr_op(o_mem_mr_op), .o_read_data(i_mem_read_data),
    .o_read_strobe(i_mem_read_strobe));

  ////////////////////////////////////////////////////////////////
  function automatic logic [15:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed;
  endfunction
  // only the fields that matter for each memory command are compared
  function automatic exp_cmd_t mk(mem_cmd_t c, logic [2:0] b, logic [13:0] r, logic [10:0] k,
      logic ap, logic [7:0] n, logic [7:0] o);
    exp_cmd_t m;
    m = '0;
    m.c = c;
    case (c)
      MEM_ACTIVE: begin m.b = b; m.r = r; end
      MEM_WRITE, MEM_READ: begin m.b = b; m.k = k; m.ap = ap; end
      MEM_MRW: begin m.n = n; m.o = o; end
      MEM_MRR: m.n = n;
      default: ;
    endcase
    return m;
  endfunction
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic fail(input string nm);
    mismatches++;
    $display("ERROR %s expected done seen timeout", nm);
    conclude();
  endtask

  ////////////////////////////////////////////////////////////////
  initial begin
    i_clock = 1'b0;
    forever #2 i_clock = ~i_clock;
  end
  initial begin
    #400000;
    fail("run");
  end
  // payload follows each write request by the configured lag
  always @(posedge i_clock) begin
    logic [15:0] a;
    logic [15:0] d;
    logic hit;
    a = rnd();
    d = rnd();
    hit = i_payload_lag2 ? req_d : (o_write_request === 1'b1);
    req_d <= (o_write_request === 1'b1);
    i_write_data <= {a, d};
    i_write_mask <= a[3:0] ^ d[15:12];
    if (hit && i_resetn === 1'b1) wq.push_back({28'h0, a[3:0] ^ d[15:12], a, d});
  end
  always @(posedge i_clock) begin
    exp_cmd_t g;
    if (i_resetn === 1'b1) begin
      g = mk(o_mem_cmd, o_mem_bank, o_mem_row, o_mem_col, o_mem_auto_precharge, o_mem_mr_num,
        o_mem_mr_op);
      if (o_mem_cmd !== MEM_NOP && ecq.size() == 0) chk("mem_cmd", '0, 64'(g));
      else if (o_mem_cmd !== MEM_NOP) chk("mem_cmd", 64'(ecq.pop_front()), 64'(g));
      if (o_read_valid !== 1'b0 && rq.size() == 0) chk("read_valid", '0, 64'(1));
      else if (o_read_valid !== 1'b0) begin
        g = '0;
        chk("read_data", rq[0] & {32'h0, rq[0][63:32]}, {32'h0, o_read_data & rq[0][63:32]});
        void'(rq.pop_front());
      end
      if (o_mem_write_strobe !== 1'b0 && wq.size() == 0) chk("write_strobe", '0, 64'(1));
      else if (o_mem_write_strobe !== 1'b0) begin
        chk("write_payload", wq.pop_front(), {28'h0, o_mem_write_mask, o_mem_write_data});
      end
      if (o_ext_refresh_ack === 1'b1) acks++;
    end
  end

  ////////////////////////////////////////////////////////////////
  task automatic issue(input logic [3:0] c, input logic [27:0] a);
    logic [15:0] x;
    int n;
    @(posedge i_clock);
    i_cmd_valid <= 1'b1;
    i_cmd <= c;
    i_addr <= a;
    n = 0;
    @(negedge i_clock);
    while (o_cmd_ready !== 1'b1 && n < 2000) begin @(negedge i_clock); n++; end
    if (n == 2000) fail("cmd_ready");
    @(posedge i_clock);
    x = rnd();
    i_cmd_valid <= 1'b0;
    i_cmd <= x[15:12];
    i_addr <= {x, x[11:0]};
  endtask
  task automatic op(input logic [3:0] c, input logic [2:0] b, input logic [13:0] r,
      input logic [10:0] k);
    logic wr;
    logic ac;
    int n;
    wr = (c == `CMD_WRITE || c == `CMD_WRITE_AC);
    ac = (c == `CMD_READ_AC || c == `CMD_WRITE_AC);
    if (open_bank[b] && open_row[b] !== r) ecq.push_back(mk(MEM_PRECHARGE, b, r, k, '0, '0, '0));
    if (!open_bank[b] || open_row[b] !== r) ecq.push_back(mk(MEM_ACTIVE, b, r, k, '0, '0, '0));
    if (wr) ecq.push_back(mk(MEM_WRITE, b, r, k, ac, '0, '0));
    else ecq.push_back(mk(MEM_READ, b, r, k, ac, '0, '0));
    if (!wr) rq.push_back({32'hFFFFFFFF, 4'h0, b, r, k});
    if (!wr) rq.push_back({32'hFFFFFFFF, 4'h4, b, r, k});
    open_bank[b] = !ac;
    open_row[b] = r;
    issue(c, {r, b, k});
    n = 0;
    while (wr && o_write_request !== 1'b1 && n < 64) begin @(negedge i_clock); n++; end
    if (n == 64) fail("write_request");
  endtask
  task automatic drain();
    int n;
    n = 0;
    while ((ecq.size() + rq.size() + wq.size() != 0 || o_cmd_ready !== 1'b1) && n < 3000) begin
      @(posedge i_clock);
      n++;
    end
    if (n == 3000) fail("drain");
  endtask
  task automatic traffic();
    logic [15:0] x;
    x = rnd();
    op(`CMD_WRITE, 3'h2, x[13:0], 11'h7FF);
    op(`CMD_WRITE, 3'h2, x[13:0], 11'h000);
    op(`CMD_WRITE, 3'h2, ~x[13:0], x[10:0]);
    op(`CMD_READ, 3'h2, ~x[13:0], 11'h001);
    op(`CMD_READ_AC, 3'h7, 14'h3FFF, x[10:0]);
    op(`CMD_READ, 3'h7, 14'h3FFF, 11'h7FF);
    op(`CMD_READ, 3'h7, 14'h0000, 11'h003);
    op(`CMD_WRITE_AC, 3'h2, ~x[13:0], 11'h400);
    op(`CMD_WRITE, 3'h2, ~x[13:0], 11'h401);
    for (int i = 0; i < 4; i++) issue(4'(i * 5), {x, x[11:0]});
  endtask
  task automatic mode_regs();
    logic [7:0] ops [16] = '{default: 8'h00};
    logic [15:0] x;
    x = rnd();
    for (int i = 1; i < 4; i++) begin
      ops[i] = x[7:0] + 8'(i * 37);
      ecq.push_back(mk(MEM_MRW, '0, '0, '0, '0, 8'(i), ops[i]));
      issue(`CMD_MRW, {12'hA5C, ops[i], 8'(i)});
    end
    drain();
    chk("burst_length_code", 64'(ops[1][2:0]), 64'(o_burst_length_code));
    chk("latency_code", 64'(ops[2][3:0]), 64'(o_latency_code));
    chk("drive_code", 64'(ops[3][3:0]), 64'(o_drive_code));
    for (int j = 2; j < 10; j += 7) begin
      ecq.push_back(mk(MEM_MRR, '0, '0, '0, '0, 8'(j), '0));
      rq.push_back({32'hFF, 24'h0, ops[j]});
      rq.push_back(64'h0);
      issue(`CMD_MRR, {12'hFFF, 8'hEE, 8'(j)});
    end
  endtask

  ////////////////////////////////////////////////////////////////
  initial begin
    i_resetn = 1'b0;
    i_cmd_valid = 1'b0;
    i_cmd = 4'h0;
    i_addr = 28'h0;
    i_payload_lag2 = 1'b0;
    i_ext_refresh_enable = 1'b1;
    i_ext_refresh_request = 1'b0;
    i_refresh_burst_count = 14'h0003;
    i_write_data = 32'h0;
    i_write_mask = 4'h0;
    slow = 1'b0;
    for (int ph = 0; ph < 2; ph++) begin
      if (ph == 1) begin
        @(posedge i_clock);
        i_resetn <= 1'b0;
        i_payload_lag2 <= 1'b1;
        i_ext_refresh_enable <= 1'b0;
        i_refresh_burst_count <= 14'h0001;
        slow <= 1'b1;
      end
      open_bank = 8'h00;
      repeat (8) @(posedge i_clock);
      i_resetn <= 1'b1;
      @(posedge i_clock);
      chk("burst_length_code", 64'(`INIT_BL), 64'(o_burst_length_code));
      chk("latency_code", 64'(`INIT_RL), 64'(o_latency_code));
      chk("drive_code", 64'(`INIT_DS), 64'(o_drive_code));
      traffic();
      if (ph == 0) begin
        ecq.push_back(mk(MEM_PRECHARGE, '0, '0, '0, '0, '0, '0));
        repeat (3) ecq.push_back(mk(MEM_REFRESH, '0, '0, '0, '0, '0, '0));
        open_bank = 8'h00;
        @(posedge i_clock);
        i_ext_refresh_request <= 1'b1;
        for (int n = 0; acks == 0 && n < 2000; n++) @(posedge i_clock);
        if (acks == 0) fail("ack");
        i_ext_refresh_request <= 1'b0;
        op(`CMD_WRITE, 3'h7, 14'h3FFF, 11'h7FF);
        mode_regs();
        repeat (300) @(posedge i_clock);
        chk("refresh_ack_count", 64'(1), 64'(acks));
      end else begin
        ecq.push_back(mk(MEM_PRECHARGE, '0, '0, '0, '0, '0, '0));
        ecq.push_back(mk(MEM_REFRESH, '0, '0, '0, '0, '0, '0));
      end
      drain();
    end
    conclude();
  end
endmodule

/* File: lpdram_mem_model.sv */
// memory-side responder: returns read beats and mode register contents
`timescale 1ns/1ps
module lpdram_mem_model (
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic i_slow,
  input wire lpdram_pkg::mem_cmd_t i_mem_cmd,
  input wire logic [2:0] i_bank,
  input wire logic [13:0] i_row,
  input wire logic [10:0] i_col,
  input wire logic [7:0] i_mr_num,
  input wire logic [7:0] i_mr_op,
  output logic [31:0] o_read_data,
  output logic o_read_strobe
);
  import lpdram_pkg::*;
  logic [7:0] mr [256];
  logic [31:0] beat0;
  logic [31:0] beat1;
  logic [2:0] wait_cnt;
  logic [1:0] left;
  logic is_mrr;
  initial begin
    for (int i = 0; i < 256; i++) begin
      mr[i] = 8'h00;
    end
  end
  assign is_mrr = (i_mem_cmd == MEM_MRR);
  always @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      wait_cnt <= 3'h0;
      left <= 2'h0;
      o_read_strobe <= 1'b0;
      o_read_data <= 32'h0;
    end else begin
      o_read_strobe <= 1'b0;
      // idle bus keeps toggling so a stale beat is never mistaken for data
      o_read_data <= ~o_read_data;
      if (i_mem_cmd == MEM_MRW) begin
        mr[i_mr_num] <= i_mr_op;
      end
      if (i_mem_cmd == MEM_READ || is_mrr) begin
        // register reads answer fast: the controller only waits a few cycles
        wait_cnt <= (i_slow && !is_mrr) ? 3'h4 : 3'h1;
        left <= 2'h2;
        beat0 <= is_mrr ? {24'h0, mr[i_mr_num]} : {4'h0, i_bank, i_row, i_col};
        beat1 <= is_mrr ? {24'hFFFFFF, ~mr[i_mr_num]} : {4'h4, i_bank, i_row, i_col};
      end else if (wait_cnt > 3'h1) begin
        wait_cnt <= wait_cnt - 3'h1;
      end else if (left != 2'h0) begin
        o_read_strobe <= 1'b1;
        o_read_data <= (left == 2'h2) ? beat0 : beat1;
        left <= left - 2'h1;
      end
    end
  end
endmodule

/* File: lpdram_pkg.sv */
// types for the lpdram command execution block
package lpdram_pkg;
  typedef enum logic [2:0] {
    MEM_NOP,
    MEM_PRECHARGE,
    MEM_ACTIVE,
    MEM_WRITE,
    MEM_READ,
    MEM_REFRESH,
    MEM_MRW,
    MEM_MRR
  } mem_cmd_t;
  typedef logic [3:0] user_cmd_t;
endpackage

/* File: lpdram_refresh.sv */
// refresh scheduler: interval timer, external request and burst sequencing
`timescale 1ns/1ps
`include "lpdram_cfg.svh"
module lpdram_refresh #(
  parameter int unsigned INTERVAL_CYC = `REFRESH_INTERVAL_CYC
) (
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic i_ext_enable,
  input wire logic i_ext_request,
  input wire logic [13:0] i_burst_count,
  input wire logic i_idle,
  output logic o_busy,
  output logic o_precharge,
  output logic o_refresh,
  output logic o_ack
);
  logic [31:0] timer_r;
  logic [31:0] timer_nxt;
  logic [13:0] left_r;
  logic [15:0] slot_r;
  logic pend_r;
  logic busy_r;
  logic first_r;
  logic req_d_r;
  logic ack_r;
  wire [31:0] period = INTERVAL_CYC * {18'h0, i_burst_count};
  wire timer_hit = !i_ext_enable && (timer_r >= period - 32'h1);
  wire ext_rise = i_ext_enable && i_ext_request && !req_d_r;
  wire slot_end = busy_r && (slot_r == 16'h0);
  wire last = slot_end && (left_r == 14'h1);
  assign timer_nxt = (i_ext_enable || timer_hit) ? 32'h0 : timer_r + 32'h1;
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      timer_r <= 32'h0;
      left_r <= 14'h0;
      slot_r <= 16'h0;
      pend_r <= 1'b0;
      busy_r <= 1'b0;
      first_r <= 1'b0;
      req_d_r <= 1'b0;
      ack_r <= 1'b0;
    end else begin
      timer_r <= timer_nxt; // see R11
      req_d_r <= i_ext_request;
      ack_r <= last && i_ext_enable; // see R14
      if (timer_hit || ext_rise) begin
        pend_r <= 1'b1;
      end else if (busy_r) begin
        pend_r <= 1'b0;
      end
      if (!busy_r && pend_r && i_idle) begin
        busy_r <= 1'b1;
        first_r <= 1'b1;
        left_r <= (i_burst_count > `MAX_BURST) ? `MAX_BURST : i_burst_count;
        slot_r <= 16'(`REFRESH_SLOT_CYC);
      end else if (busy_r) begin
        first_r <= 1'b0;
        if (slot_end) begin
          left_r <= left_r - 14'h1;
          slot_r <= 16'(`REFRESH_SLOT_CYC);
          busy_r <= !last;
        end else begin
          slot_r <= slot_r - 16'h1;
        end
      end
    end
  end
  // precharge only in front of the first refresh of a burst
  assign o_precharge = first_r; // see R13
  assign o_refresh = busy_r && (slot_r == 16'(`REFRESH_SLOT_CYC - 1));
  assign o_busy = busy_r || (pend_r && i_idle); // see R12
  assign o_ack = ack_r;

  first_once_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    o_precharge |=> !o_precharge) else $error("precharge repeated in burst"); // see R13
  ext_no_timer_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    i_ext_enable |=> timer_r == 32'h0) else $error("timer ran in external mode"); // see R14
endmodule
